// ---- common/wqcr_map.svh ----
// Purpose: Offsets, field positions and reset values of the WRED register bank
// Assumes: Offsets are byte addresses within one port block
// Notes: Definitions only
`ifndef WQCR_MAP_SVH
`define WQCR_MAP_SVH
`define WQCR_AW 12
`define WQCR_OFS_PORT_PTR 12'h804
`define WQCR_OFS_POLICE 12'h80c
`define WQCR_OFS_PM_A 12'h830
`define WQCR_OFS_PM_B 12'h834
`define WQCR_OFS_Q_THR 12'h840
`define WQCR_OFS_Q_PROB 12'h844
`define WQCR_OFS_Q_MON 12'h848
`define WQCR_OFS_TXQ_IDX 12'h900
`define WQCR_OFS_TXQ_IDX_B 12'h903
`define WQCR_OFS_VLAN_REP 12'h904
`define WQCR_HI_LSB 16
`define WQCR_PORT_LSB 16
`define WQCR_POL_EN_BIT 0
`define WQCR_POL_PMALL_BIT 10
`define WQCR_POL_W 12
`define WQCR_MON_RND_BIT 31
`define WQCR_MON_FLUSH_BIT 30
`define WQCR_MON_GYR_BIT 29
`define WQCR_MON_YR_BIT 28
`define WQCR_MON_R_BIT 27
`define WQCR_MON_ALL_BIT 26
`define WQCR_RST_PM_MULT 11'h020
`define WQCR_RST_PM_MAX 11'h400
`define WQCR_RST_PM_MIN 11'h080
`define WQCR_RST_Q_MAX 11'h080
`define WQCR_RST_Q_MIN 11'h009
`define WQCR_RST_Q_MULT 11'h010
`define WQCR_LFSR_SEED 11'h5a5
`define WQCR_ENTRIES 32
`endif

// ---- common/wqcr_pkg.sv ----
// Purpose: Types shared by the WRED register bank
// Assumes: Eight ports, four queues, three colours
// Notes: Colour codes follow the monitor packet type encoding
package wqcr_pkg;
  typedef enum logic [1:0] {
    WQCR_COL_NONE = 2'h0,
    WQCR_COL_GREEN = 2'h1,
    WQCR_COL_YELLOW = 2'h2,
    WQCR_COL_RED = 2'h3
  } wqcr_colour_t;
  typedef struct packed {
    logic valid;
    logic [2:0] port;
    logic [1:0] queue;
    wqcr_colour_t colour;
    logic [10:0] avg;
  } wqcr_pkt_t;
  typedef struct packed {
    logic valid;
    logic double_tag;
    logic [11:0] inner_vid;
    logic [11:0] outer_vid;
  } wqcr_tag_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wqcr_bus_t;
endpackage : wqcr_pkg

// ---- rtl/wqcr_bank.sv ----
// Purpose: WRED congestion register bank of one port, with drop decision and egress VID swap
// Assumes: Single 40 MHz clock, synchronous active-high reset, plain register port
// Notes: Per-queue entries are indexed by port index and queue pointer
`timescale 1ns/1ps
`default_nettype none
`include "wqcr_map.svh"

// What this block does
// - Packet-memory multiplier, bits 26:16, reset 0x020
// - Packet-memory average size read-only, bits 10:0
// - Per-queue max threshold, bits 26:16, reset 0x080
// - Per-queue min threshold, bits 10:0, reset 0x009
// - Per-queue multiplier, bits 26:16, reset 0x010
// - Selected queue average size read-only, bits 10:0
// - Random drop only when bit 31 set
// - Rising edge of bit 30 clears counters
// - Bit 29 inhibits dropping all colours
// - Bit 28 inhibits dropping yellow and red
// - Bit 27 inhibits dropping red
// - Bit 26 drops all above max
// - 24-bit event counter, cleared by flush edge
// - Two-bit egress queue index, reset 00
// - Queue index byte access at 0x903
// - Bit 0 swaps non-zero VID for default
// - Double tagging swaps outer provider tag
// - Port index 18:16, queue pointer 1:0
// - Packet-memory max 0x400, min 0x080
// - WRED only while police enable set
module wqcr_bank (
  input wire logic clk,
  input wire logic rst,
  input wire wqcr_pkg::wqcr_bus_t bus,
  output logic [31:0] rdata,
  input wire wqcr_pkg::wqcr_pkt_t pkt,
  input wire logic [10:0] pm_avg,
  output logic drop_valid,
  output logic drop,
  input wire wqcr_pkg::wqcr_tag_t tag_in,
  input wire logic [11:0] default_vid,
  output wqcr_pkg::wqcr_tag_t tag_out,
  output logic [1:0] tx_queue_index
);
  import wqcr_pkg::*;

  function automatic logic [4:0] entry_of(input logic [2:0] p, input logic [1:0] q);
    entry_of = {p, q};
  endfunction : entry_of

  // Linear ramp from min to max; saturates once the product leaves the compare range
  function automatic logic wred_hit(input logic [10:0] avg, input logic [10:0] mn,
                                    input logic [10:0] mx, input logic [10:0] mult,
                                    input logic [10:0] rnd, input logic all_en,
                                    input logic rnd_en);
    logic [10:0] ex;
    logic [21:0] prod;
    logic ramp;
    ex = avg - mn;
    prod = {11'h000, ex} * {11'h000, mult};
    ramp = (|prod[21:16]) | (prod[15:5] > rnd);
    if (avg < mn) begin
      wred_hit = 1'b0;
    end else if (avg > mx && all_en) begin
      wred_hit = 1'b1;
    end else begin
      wred_hit = rnd_en & ramp;
    end
  endfunction : wred_hit

  // Port-level control
  logic [2:0] port_idx_q;
  logic [1:0] queue_ptr_q;
  logic [`WQCR_POL_W-1:0] police_q;
  logic [10:0] pm_max_q;
  logic [10:0] pm_min_q;
  logic [10:0] pm_mult_q;
  logic [10:0] pm_avg_q;
  logic [5:0] mon_q;
  logic [1:0] txq_idx_q;
  logic vid_rep_q;
  logic [10:0] lfsr_q;
  logic [31:0] rdata_q;
  logic drop_valid_q;
  logic drop_q;
  wqcr_tag_t tag_q;

  // Per-entry storage
  logic [10:0] q_max_q [`WQCR_ENTRIES];
  logic [10:0] q_min_q [`WQCR_ENTRIES];
  logic [10:0] q_mult_q [`WQCR_ENTRIES];
  logic [10:0] q_avg_q [`WQCR_ENTRIES];
  logic [23:0] q_cnt_q [`WQCR_ENTRIES];

  // Decode
  wire [4:0] sel_entry = entry_of(port_idx_q, queue_ptr_q);
  wire [4:0] pkt_entry = entry_of(pkt.port, pkt.queue);
  wire wr_ptr = bus.wr && bus.addr == `WQCR_OFS_PORT_PTR;
  wire wr_pol = bus.wr && bus.addr == `WQCR_OFS_POLICE;
  wire wr_pma = bus.wr && bus.addr == `WQCR_OFS_PM_A;
  wire wr_pmb = bus.wr && bus.addr == `WQCR_OFS_PM_B;
  wire wr_thr = bus.wr && bus.addr == `WQCR_OFS_Q_THR;
  wire wr_prob = bus.wr && bus.addr == `WQCR_OFS_Q_PROB;
  wire wr_mon = bus.wr && bus.addr == `WQCR_OFS_Q_MON;
  wire wr_txq = bus.wr && bus.addr == `WQCR_OFS_TXQ_IDX;
  wire wr_txq_b = bus.wr && bus.addr == `WQCR_OFS_TXQ_IDX_B;
  wire wr_vid = bus.wr && bus.addr == `WQCR_OFS_VLAN_REP;
  wire [31:0] wd = bus.wdata;
  wire [10:0] wd_hi = wd[`WQCR_HI_LSB+10:`WQCR_HI_LSB];
  wire [10:0] wd_lo = wd[10:0];

  // Flush acts on the written 0-to-1 change only, so a steady one clears nothing
  wire flush_edge = wr_mon && wd[`WQCR_MON_FLUSH_BIT] && !mon_q[4];

  // Drop decision
  wire pol_en = police_q[`WQCR_POL_EN_BIT];
  wire pm_all = police_q[`WQCR_POL_PMALL_BIT];
  wire rnd_en = mon_q[5];
  wire inh_gyr = mon_q[3];
  wire inh_yr = mon_q[2];
  wire inh_r = mon_q[1];
  wire q_all = mon_q[0];
  wire is_yr = pkt.colour == WQCR_COL_YELLOW || pkt.colour == WQCR_COL_RED;
  wire is_r = pkt.colour == WQCR_COL_RED;
  wire inhibit = inh_gyr | (inh_yr & is_yr) | (inh_r & is_r);
  wire q_hit = wred_hit(pkt.avg, q_min_q[pkt_entry], q_max_q[pkt_entry],
                        q_mult_q[pkt_entry], lfsr_q, q_all, rnd_en);
  wire pm_hit = wred_hit(pm_avg, pm_min_q, pm_max_q, pm_mult_q,
                         lfsr_q, pm_all, rnd_en);
  wire drop_d = pkt.valid && pol_en && !inhibit && (q_hit || pm_hit);
  wire lfsr_fb = lfsr_q[10] ^ lfsr_q[8];

  // Egress VID swap
  wire rep_outer = vid_rep_q && tag_in.double_tag && tag_in.outer_vid != 12'h000;
  wire rep_inner = vid_rep_q && !tag_in.double_tag && tag_in.inner_vid != 12'h000;
  wqcr_tag_t tag_d;
  assign tag_d.valid = tag_in.valid;
  assign tag_d.double_tag = tag_in.double_tag;
  assign tag_d.outer_vid = rep_outer ? default_vid : tag_in.outer_vid;
  assign tag_d.inner_vid = rep_inner ? default_vid : tag_in.inner_vid;

  // Read mux; unmapped offsets and reserved bits read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (bus.addr)
      `WQCR_OFS_PORT_PTR: rd_mux = {13'h0000, port_idx_q, 14'h0000, queue_ptr_q};
      `WQCR_OFS_POLICE: rd_mux = {20'h00000, police_q};
      `WQCR_OFS_PM_A: rd_mux = {5'h00, pm_max_q, 5'h00, pm_min_q};
      `WQCR_OFS_PM_B: rd_mux = {5'h00, pm_mult_q, 5'h00, pm_avg_q};
      `WQCR_OFS_Q_THR: rd_mux = {5'h00, q_max_q[sel_entry], 5'h00, q_min_q[sel_entry]};
      `WQCR_OFS_Q_PROB: rd_mux = {5'h00, q_mult_q[sel_entry], 5'h00, q_avg_q[sel_entry]};
      `WQCR_OFS_Q_MON: rd_mux = {mon_q, 2'h0, q_cnt_q[sel_entry]};
      `WQCR_OFS_TXQ_IDX: rd_mux = {30'h00000000, txq_idx_q};
      `WQCR_OFS_TXQ_IDX_B: rd_mux = {30'h00000000, txq_idx_q};
      `WQCR_OFS_VLAN_REP: rd_mux = {31'h00000000, vid_rep_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_idx_q <= 3'h0;
      queue_ptr_q <= 2'h0;
    end else if (wr_ptr) begin
      port_idx_q <= wd[`WQCR_PORT_LSB+2:`WQCR_PORT_LSB];
      queue_ptr_q <= wd[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      police_q <= 12'h000;
    end else if (wr_pol) begin
      police_q <= wd[`WQCR_POL_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pm_max_q <= `WQCR_RST_PM_MAX;
      pm_min_q <= `WQCR_RST_PM_MIN;
    end else if (wr_pma) begin
      pm_max_q <= wd_hi;
      pm_min_q <= wd_lo;
    end
  end

  // Average field ignores writes; it follows the memory occupancy only
  always_ff @(posedge clk) begin
    if (rst) begin
      pm_mult_q <= `WQCR_RST_PM_MULT;
      pm_avg_q <= 11'h000;
    end else begin
      if (wr_pmb) begin
        pm_mult_q <= wd_hi;
      end
      pm_avg_q <= pm_avg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mon_q <= 6'h00;
    end else if (wr_mon) begin
      mon_q <= wd[`WQCR_MON_RND_BIT:`WQCR_MON_ALL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txq_idx_q <= 2'h0;
    end else if (wr_txq || wr_txq_b) begin
      txq_idx_q <= wd[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vid_rep_q <= 1'b0;
    end else if (wr_vid) begin
      vid_rep_q <= wd[0];
    end
  end

  // A maximal-length LFSR is cheap and good enough for drop dithering
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_q <= `WQCR_LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[9:0], lfsr_fb};
    end
  end

  genvar e;
  generate
    for (e = 0; e < `WQCR_ENTRIES; e++) begin : g_entry
      wire sel_e = sel_entry == 5'(e);
      wire hit_e = drop_d && pkt_entry == 5'(e);
      always_ff @(posedge clk) begin
        if (rst) begin
          q_max_q[e] <= `WQCR_RST_Q_MAX;
          q_min_q[e] <= `WQCR_RST_Q_MIN;
        end else if (wr_thr && sel_e) begin
          q_max_q[e] <= wd_hi;
          q_min_q[e] <= wd_lo;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          q_mult_q[e] <= `WQCR_RST_Q_MULT;
        end else if (wr_prob && sel_e) begin
          q_mult_q[e] <= wd_hi;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          q_avg_q[e] <= 11'h000;
        end else if (pkt.valid && pkt_entry == 5'(e)) begin
          q_avg_q[e] <= pkt.avg;
        end
      end
      // An event in the flush cycle survives as a count of one
      always_ff @(posedge clk) begin
        if (rst) begin
          q_cnt_q[e] <= 24'h000000;
        end else if (flush_edge) begin
          q_cnt_q[e] <= {23'h000000, hit_e};
        end else if (hit_e) begin
          q_cnt_q[e] <= q_cnt_q[e] + 24'h000001;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
      drop_valid_q <= 1'b0;
      drop_q <= 1'b0;
      tag_q <= '0;
    end else begin
      rdata_q <= bus.rd ? rd_mux : 32'h00000000;
      drop_valid_q <= pkt.valid;
      drop_q <= drop_d;
      tag_q <= tag_d;
    end
  end

  assign rdata = rdata_q;
  assign drop_valid = drop_valid_q;
  assign drop = drop_q;
  assign tag_out = tag_q;
  assign tx_queue_index = txq_idx_q;
endmodule : wqcr_bank
`default_nettype wire

// ---- bench/wqcr_bank_sva.sv ----
// Purpose: Port-level checks of the WRED register bank
// Assumes: Control bits are tracked from bus writes, since register state is not visible
// Notes: Ramp decisions are not checked here, the noise source is private to the design
`timescale 1ns/1ps
`default_nettype none
module wqcr_bank_sva (
  input wire logic clk,
  input wire logic rst,
  input wire wqcr_pkg::wqcr_bus_t bus,
  input wire wqcr_pkg::wqcr_pkt_t pkt,
  input wire logic drop,
  input wire wqcr_pkg::wqcr_tag_t tag_in,
  input wire logic [11:0] default_vid,
  input wire wqcr_pkg::wqcr_tag_t tag_out,
  input wire logic [1:0] tx_queue_index
);
  import wqcr_pkg::*;
  logic [5:0] mon_q;
  logic [1:0] pol_q;
  logic rep_q;
  wire wr_mon = bus.wr && bus.addr == 12'h848;
  wire wr_pol = bus.wr && bus.addr == 12'h80c;
  wire wr_rep = bus.wr && bus.addr == 12'h904;
  wire wr_txq = bus.wr && (bus.addr == 12'h900 || bus.addr == 12'h903);
  always_ff @(posedge clk) begin
    if (rst) begin
      mon_q <= '0;
      pol_q <= '0;
      rep_q <= 1'b0;
    end else begin
      if (wr_mon) mon_q <= bus.wdata[31:26];
      if (wr_pol) pol_q <= {bus.wdata[10], bus.wdata[0]};
      if (wr_rep) rep_q <= bus.wdata[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_pol; pkt.valid && !pol_q[0] |=> !drop; endproperty
  a_pol: assert property (p_pol) else $error("drop while policing off");
  property p_gyr; pkt.valid && mon_q[3] |=> !drop; endproperty
  a_gyr: assert property (p_gyr) else $error("drop while all colours inhibited");
  property p_yr; pkt.valid && mon_q[2] && pkt.colour > 1 |=> !drop; endproperty
  a_yr: assert property (p_yr) else $error("yellow or red dropped");
  property p_red; pkt.valid && mon_q[1] && pkt.colour == 3 |=> !drop; endproperty
  a_red: assert property (p_red) else $error("red dropped");
  property p_rnd; pkt.valid && !mon_q[5] && !mon_q[0] && !pol_q[1] |=> !drop; endproperty
  a_rnd: assert property (p_rnd) else $error("ramp drop while random off");
  property p_txq; wr_txq |=> tx_queue_index == $past(bus.wdata[1:0]); endproperty
  a_txq: assert property (p_txq) else $error("queue index not updated");
  property p_keep; !rep_q |=> tag_out == $past(tag_in); endproperty
  a_keep: assert property (p_keep) else $error("tag changed without swap");
  property p_vid;
    rep_q && !tag_in.double_tag && tag_in.inner_vid != 0 |=> ##0
      tag_out.inner_vid == $past(default_vid) && tag_out.outer_vid == $past(tag_in.outer_vid);
  endproperty
  a_vid: assert property (p_vid) else $error("inner id not swapped");
  property p_isp;
    rep_q && tag_in.double_tag && tag_in.outer_vid != 0 |-> ##1
      tag_out.outer_vid == $past(default_vid) && tag_out.inner_vid == $past(tag_in.inner_vid);
  endproperty
  a_isp: assert property (p_isp) else $error("outer tag not swapped");
endmodule : wqcr_bank_sva
bind wqcr_bank wqcr_bank_sva u_sva (.clk(clk), .rst(rst), .bus(bus), .pkt(pkt), .drop(drop),
  .tag_in(tag_in), .default_vid(default_vid), .tag_out(tag_out),
  .tx_queue_index(tx_queue_index));
`default_nettype wire

// ---- bench/test_wqcr_bank.sv ----
// Purpose: Self-checking bench for the WRED register bank
// Assumes: 40 MHz clock, sync reset held 16 cycles
// Notes: Random traffic keeps random drop off, so every decision is predictable
`timescale 1ns/1ps
`default_nettype none
module test_wqcr_bank;
  import wqcr_pkg::*;
  logic clk = 0;
  logic rst = 1;
  wqcr_bus_t bus = '0;
  wqcr_pkt_t pkt = '0;
  wqcr_tag_t tag_in = '0;
  wqcr_tag_t tag_out;
  wqcr_tag_t t;
  logic [10:0] pm_avg = '0;
  logic [11:0] default_vid = '0;
  logic [11:0] v;
  logic [11:0] a;
  logic [31:0] rdata;
  logic drop_valid;
  logic drop;
  logic [1:0] tx_queue_index;
  int fail_count = 0;
  int comparisons = 0;
  int qmax[32], qmin[32], qmul[32], qavg[32], cnt[32];
  logic [4:0] ptr = 0;
  logic [11:0] pol = 0;
  logic [5:0] mon = 0;
  logic [10:0] pmx = 11'h400, pmn = 11'h080, pmm = 11'h020;
  logic [1:0] txq = 0;
  logic rep = 0;
  logic [11:0] amap[12] = '{12'h804, 12'h80c, 12'h830, 12'h834, 12'h840, 12'h844,
    12'h848, 12'h900, 12'h903, 12'h904, 12'h808, 12'h9fc};
  wqcr_bank DUT (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .pkt(pkt), .pm_avg(pm_avg),
    .drop_valid(drop_valid), .drop(drop), .tag_in(tag_in), .default_vid(default_vid),
    .tag_out(tag_out), .tx_queue_index(tx_queue_index));
  initial forever #12.5 clk = ~clk;
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    #2500000;
    fail_count++;
    results();
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [31:0] mrd(logic [11:0] ad);
    case (ad)
      12'h804: return {13'h0, ptr[4:2], 14'h0, ptr[1:0]};
      12'h80c: return {20'h0, pol};
      12'h830: return {5'h0, pmx, 5'h0, pmn};
      12'h834: return {5'h0, pmm, 5'h0, pm_avg};
      12'h840: return {5'h0, 11'(qmax[ptr]), 5'h0, 11'(qmin[ptr])};
      12'h844: return {5'h0, 11'(qmul[ptr]), 5'h0, 11'(qavg[ptr])};
      12'h848: return {mon, 2'h0, 24'(cnt[ptr])};
      12'h900, 12'h903: return {30'h0, txq};
      12'h904: return {31'h0, rep};
      default: return 32'h0;
    endcase
  endfunction : mrd
  task automatic wr(logic [11:0] ad, logic [31:0] d);
    bus <= {ad, d, 2'b10};
    @(posedge clk);
    bus.wr <= 1'b0;
    case (ad)
      12'h804: ptr = {d[18:16], d[1:0]};
      12'h80c: pol = d[11:0];
      12'h830: {pmx, pmn} = {d[26:16], d[10:0]};
      12'h834: pmm = d[26:16];
      12'h840: {qmax[ptr], qmin[ptr]} = {21'h0, d[26:16], 21'h0, d[10:0]};
      12'h844: qmul[ptr] = d[26:16];
      12'h848: begin
        if (d[30] && !mon[4]) cnt = '{default: 0};
        mon = d[31:26];
      end
      12'h900, 12'h903: txq = d[1:0];
      12'h904: rep = d[0];
      default: ;
    endcase
    #1 chk("tx_queue_index", txq, tx_queue_index);
    @(posedge clk);
  endtask : wr
  task automatic rd(logic [11:0] ad);
    bus <= {ad, 32'h0, 2'b01};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk("rdata", mrd(ad), rdata);
    @(posedge clk);
    // Read data stands one cycle only, then the port returns zero
    #1 chk("rdata_idle", 32'h00000000, rdata);
  endtask : rd
  // Ramp with random drop on is only predictable when the product saturates
  function automatic bit xdrop(wqcr_pkt_t p, int pa);
    int e;
    int av;
    e = {p.port, p.queue};
    av = p.avg;
    if (!pol[0] || mon[3] || mon[2] && p.colour > 1 || mon[1] && p.colour == 3) return 0;
    if (pa >= pmn && pa > pmx && pol[10]) return 1;
    return av >= qmin[e] && (av > qmax[e] && mon[0] || mon[5] && (av - qmin[e]) * qmul[e] > 65535);
  endfunction : xdrop
  task automatic send(int port, int q, int c, int av, int pa);
    wqcr_pkt_t p;
    bit x;
    p = {1'b1, 3'(port), 2'(q), 2'(c), 11'(av)};
    x = xdrop(p, pa);
    pkt <= p;
    pm_avg <= 11'(pa);
    @(posedge clk);
    pkt.valid <= 1'b0;
    #1 chk("drop", {1'b1, x}, {drop_valid, drop});
    qavg[{p.port, p.queue}] = p.avg;
    if (x) cnt[{p.port, p.queue}]++;
    @(posedge clk);
  endtask : send
  function automatic wqcr_tag_t xtag(wqcr_tag_t ti, logic [11:0] dv);
    if (rep && ti.double_tag && ti.outer_vid != 0) ti.outer_vid = dv;
    if (rep && !ti.double_tag && ti.inner_vid != 0) ti.inner_vid = dv;
    return ti;
  endfunction : xtag
  initial begin
    void'($urandom(32'h14c0));
    qmax = '{default: 'h80};
    qmin = '{default: 9};
    qmul = '{default: 'h10};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (amap[i]) rd(amap[i]);
    repeat (120) begin
      a = amap[$urandom % 12];
      wr(a, $urandom);
      rd(a);
    end
    for (int i = 0; i < 300; i++) begin
      if (i % 20 == 0) begin
        wr(12'h848, $urandom & 32'h7fffffff);
        wr(12'h80c, $urandom);
      end
      send($urandom, $urandom, 1 + $urandom % 3, $urandom, $urandom);
    end
    for (int e = 0; e < 32; e++) begin
      wr(12'h804, {e[4:2], 14'h0, e[1:0]});
      rd(12'h844);
      rd(12'h848);
    end
    wr(12'h830, 32'h04000080);
    wr(12'h80c, 32'h1);
    wr(12'h804, 32'h0);
    wr(12'h848, 32'h04000000);
    wr(12'h840, 32'h00020005);
    send(0, 0, 1, 'h4, 0);
    send(0, 0, 1, 'h5, 0);
    wr(12'h840, 32'h00100005);
    send(0, 0, 1, 'h10, 0);
    send(0, 0, 1, 'h11, 0);
    rd(12'h848);
    wr(12'h848, 32'h44000000);
    rd(12'h848);
    send(0, 0, 3, 'h11, 0);
    wr(12'h848, 32'h44000000);
    rd(12'h848);
    for (int b = 27; b < 30; b++)
      for (int c = 1; c < 4; c++) begin
        wr(12'h848, 32'h04000000 | 1 << b);
        send(0, 0, c, 'h11, 0);
      end
    wr(12'h80c, 32'h0);
    send(0, 0, 1, 'h11, 0);
    wr(12'h80c, 32'h401);
    wr(12'h848, 32'h0);
    send(0, 0, 1, 0, 'h401);
    send(0, 0, 1, 0, 'h400);
    wr(12'h840, 32'h07ff0000);
    wr(12'h844, 32'h00400000);
    wr(12'h848, 32'h80000000);
    send(0, 0, 1, 'h400, 0);
    wr(12'h848, 32'h0);
    send(0, 0, 1, 'h400, 0);
    for (int i = 0; i < 64; i++) begin
      if (i % 16 == 0) wr(12'h904, $urandom);
      t = $urandom;
      if (i % 4 == 0) t[23:0] = '0;
      v = $urandom;
      tag_in <= t;
      default_vid <= v;
      @(posedge clk);
      #1 chk("tag_out", xtag(t, v), tag_out);
      @(posedge clk);
    end
    results();
  end
endmodule : test_wqcr_bank
`default_nettype wire
